// *** hw/lvd_pkg.sv ***
/*
  Constants, register map and carrier types for the low-voltage and stop
  control block.
  Assumes an 8-bit register port with a 3-bit word address.
*/
package supply_ctrl_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [2:0] OFS_ONE     = 3'h0; // Status and control one
  localparam logic [2:0] OFS_TWO     = 3'h1; // Status and control two
  localparam logic [2:0] OFS_EVT_ST  = 3'h2; // Event status, read only
  localparam logic [2:0] OFS_EVT_CLR = 3'h3; // Event clear, write only
  localparam logic [2:0] OFS_EVT_EN  = 3'h4; // Event enable

  // ==========================================================================
  // Field positions, register one
  localparam int B1_FLAG = 7; // Warning flag
  localparam int B1_ACK  = 6; // Warning acknowledge
  localparam int B1_WIE  = 5; // Warning interrupt enable
  localparam int B1_DRE  = 4; // Detect reset enable
  localparam int B1_DSE  = 3; // Detect stop enable
  localparam int B1_DE   = 2; // Detect enable
  localparam int B1_BUFE = 0; // Bandgap buffer enable

  // Field positions, register two
  localparam int B2_DVS  = 5; // Detect voltage select
  localparam int B2_WVS  = 4; // Warning voltage select
  localparam int B2_RCVR = 3; // Partial power down flag
  localparam int B2_ACK  = 2; // Partial power down acknowledge
  localparam int B2_SMS  = 0; // Stop mode select

  // Event bits
  localparam int EV_WARN = 0; // Warning condition arose
  localparam int EV_DET  = 1; // Detect condition arose
  localparam int EV_PPD  = 2; // Recovery from partial power down
  localparam int EV_W    = 3;

  // ==========================================================================
  // Carrier for the software-set control bits of register one
  typedef struct packed {
    logic warning_interrupt_enable;
    logic detect_reset_enable;
    logic detect_stop_enable;
    logic detect_enable;
    logic bandgap_buffer_enable;
  } ctrl_t;

  // Values after reset
  localparam ctrl_t CTRL_RST = '{
    warning_interrupt_enable: 1'b0,
    detect_reset_enable:      1'b1,
    detect_stop_enable:       1'b0,
    detect_enable:            1'b1,
    bandgap_buffer_enable:    1'b0
  };
  localparam logic [7:0]      RDATA_RST = 8'h00;
  localparam logic [EV_W-1:0] EVT_RST   = 3'h0;

endpackage : supply_ctrl_pkg

// *** hw/low_voltage_and_stop_control.sv ***
/*
  Low-voltage detect / warning control, stop mode select and partial
  power down recovery flag, with a small event interrupt unit.
  Assumes comparator outputs, stop state and the power-on indication are
  synchronous to clk_in; por_in is high during a power-on reset.
*/
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps

module low_voltage_and_stop_control
  import supply_ctrl_pkg::*;
(
  input  wire logic       clk_in,                 // Bus clock, 100 MHz
  input  wire logic       rst_n_in,               // Synchronous reset, any cause
  input  wire logic       por_in,                 // Current reset is power-on
  input  wire logic [2:0] addr_in,                // Register word address
  input  wire logic [7:0] wdata_in,               // Write data
  input  wire logic       wr_in,                  // Write strobe
  input  wire logic       rd_in,                  // Read strobe
  output logic      [7:0] rdata_out,              // Read data, cycle after rd
  input  wire logic       below_warning_in,       // Supply below warning point
  input  wire logic       below_detect_in,        // Supply below detect point
  input  wire logic       stop_in,                // Device is in a stop mode
  input  wire logic       ppd_recovered_in,       // Pulse: left deep stop
  output logic            detect_active_out,      // Comparator enable
  output logic            detect_reset_out,       // Force a full reset
  output logic            bandgap_buffer_enable_out, // Reference buffer on
  output logic            stop_mode_select_out,   // 1 partial power down stop
  output logic            detect_trip_code_out,   // Detect trip point code
  output logic      [1:0] warning_trip_code_out,  // Warning trip point code
  output logic            irq_out                 // Level interrupt request
);

  // ==========================================================================
  // State
  ctrl_t           ctrl_q;
  logic            lock_one_q;
  logic            lock_two_q;
  logic            lock_volt_q;
  logic            warning_flag_q;
  logic            ppd_flag_q;
  logic            stop_mode_select_q;
  logic            detect_voltage_select_q;
  logic            warning_voltage_select_q;
  logic            detect_reset_q;
  logic            warn_prev_q;
  logic            det_prev_q;
  logic [EV_W-1:0] evt_status_q;
  logic [EV_W-1:0] evt_enable_q;
  logic [EV_W-1:0] evt_set;
  logic [7:0]      rdata_q;
  logic [7:0]      rdata_d;
  logic            wr_one;
  logic            wr_two;
  logic            detect_active;
  logic            warn_cond;
  logic            det_cond;

  // ==========================================================================
  // Decode and qualified conditions
  assign wr_one = wr_in && (addr_in == OFS_ONE);
  assign wr_two = wr_in && (addr_in == OFS_TWO);

  // Stop mode gates detection unless software keeps it alive
  assign detect_active = ctrl_q.detect_enable
                         && (!stop_in || ctrl_q.detect_stop_enable);
  assign warn_cond = detect_active && below_warning_in;
  assign det_cond  = detect_active && below_detect_in;

  // ==========================================================================
  // Register one control bits; reset and detect enables lock after one write
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_one) begin
      ctrl_q.warning_interrupt_enable <= wdata_in[B1_WIE];
      ctrl_q.detect_stop_enable       <= wdata_in[B1_DSE];
      ctrl_q.bandgap_buffer_enable    <= wdata_in[B1_BUFE];
      if (!lock_one_q) begin
        ctrl_q.detect_reset_enable <= wdata_in[B1_DRE];
        ctrl_q.detect_enable       <= wdata_in[B1_DE];
      end
    end
  end

  // Lock for register one, re-armed by every reset
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      lock_one_q <= 1'b0;
    end else if (wr_one) begin
      lock_one_q <= 1'b1;
    end
  end

  // ==========================================================================
  // Stop mode select, write-once per reset
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      stop_mode_select_q <= 1'b0;
      lock_two_q         <= 1'b0;
    end else if (wr_two) begin
      lock_two_q <= 1'b1;
      if (!lock_two_q) begin
        stop_mode_select_q <= wdata_in[B2_SMS];
      end
    end
  end

  // Voltage selects survive every reset but power-on, so a detect reset
  // cannot drop the trip point software chose
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      if (por_in) begin
        detect_voltage_select_q  <= 1'b0;
        warning_voltage_select_q <= 1'b0;
        lock_volt_q              <= 1'b0;
      end
    end else if (wr_two) begin
      warning_voltage_select_q <= wdata_in[B2_WVS];
      lock_volt_q              <= 1'b1;
      if (!lock_volt_q) begin
        detect_voltage_select_q <= wdata_in[B2_DVS];
      end
    end
  end

  // ==========================================================================
  // Warning flag; a live condition beats the acknowledge
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      warning_flag_q <= 1'b0;
    end else if (warn_cond) begin
      warning_flag_q <= 1'b1;
    end else if (wr_one && wdata_in[B1_ACK]) begin
      warning_flag_q <= 1'b0;
    end
  end

  // Partial power down flag; recovery pulse beats the acknowledge
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ppd_flag_q <= 1'b0;
    end else if (ppd_recovered_in) begin
      ppd_flag_q <= 1'b1;
    end else if (wr_two && wdata_in[B2_ACK]) begin
      ppd_flag_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Reset request, registered so a comparator glitch lasts a whole cycle
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      detect_reset_q <= 1'b0;
    end else begin
      detect_reset_q <= det_cond && ctrl_q.detect_reset_enable;
    end
  end

  // ==========================================================================
  // Event unit: edges of the conditions, plus recovery
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      warn_prev_q <= 1'b0;
      det_prev_q  <= 1'b0;
    end else begin
      warn_prev_q <= warn_cond;
      det_prev_q  <= det_cond;
    end
  end

  assign evt_set = {ppd_recovered_in, det_cond && !det_prev_q, warn_cond && !warn_prev_q};

  // Sticky status; a set in the clearing cycle survives
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      evt_status_q <= EVT_RST;
    end else if (wr_in && (addr_in == OFS_EVT_CLR)) begin
      evt_status_q <= (evt_status_q & ~wdata_in[EV_W-1:0]) | evt_set;
    end else begin
      evt_status_q <= evt_status_q | evt_set;
    end
  end

  // Event enable
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      evt_enable_q <= EVT_RST;
    end else if (wr_in && (addr_in == OFS_EVT_EN)) begin
      evt_enable_q <= wdata_in[EV_W-1:0];
    end
  end

  // ==========================================================================
  // Read mux; acknowledge and unused bits read zero
  always_comb begin
    rdata_d = 8'h00;
    case (addr_in)
      OFS_ONE: begin
        rdata_d[B1_FLAG] = warning_flag_q;
        rdata_d[B1_WIE]  = ctrl_q.warning_interrupt_enable;
        rdata_d[B1_DRE]  = ctrl_q.detect_reset_enable;
        rdata_d[B1_DSE]  = ctrl_q.detect_stop_enable;
        rdata_d[B1_DE]   = ctrl_q.detect_enable;
        rdata_d[B1_BUFE] = ctrl_q.bandgap_buffer_enable;
      end
      OFS_TWO: begin
        rdata_d[B2_DVS]  = detect_voltage_select_q;
        rdata_d[B2_WVS]  = warning_voltage_select_q;
        rdata_d[B2_RCVR] = ppd_flag_q;
        rdata_d[B2_SMS]  = stop_mode_select_q;
      end
      OFS_EVT_ST: rdata_d[EV_W-1:0] = evt_status_q;
      OFS_EVT_EN: rdata_d[EV_W-1:0] = evt_enable_q;
      default:    rdata_d = 8'h00;
    endcase
  end

  // Data valid only in the cycle after the strobe
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rdata_q <= RDATA_RST;
    end else if (rd_in) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // ==========================================================================
  // Outputs
  assign rdata_out                 = rdata_q;
  assign detect_active_out         = detect_active;
  assign detect_reset_out          = detect_reset_q;
  assign bandgap_buffer_enable_out = ctrl_q.bandgap_buffer_enable;
  assign stop_mode_select_out      = stop_mode_select_q;
  assign detect_trip_code_out      = detect_voltage_select_q;
  assign warning_trip_code_out     = {detect_voltage_select_q,
                                      warning_voltage_select_q};
  // Warning interrupt plus any enabled event
  assign irq_out = (warning_flag_q && ctrl_q.warning_interrupt_enable)
                   || |(evt_status_q & evt_enable_q);

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  // The sampled reset in the antecedent keeps the release edge out: the
  // disable condition has already dropped there while the flag still waits
  AST_WARN_SET: assert property (rst_n_in && warn_cond |=> warning_flag_q)
    else $error("Warning flag not set by condition");

  AST_WARN_HOLD: assert property (
    warning_flag_q && !(wr_one && wdata_in[B1_ACK]) |=> warning_flag_q)
    else $error("Warning flag dropped without acknowledge");

  AST_WARN_ACK: assert property (
    wr_one && wdata_in[B1_ACK] && !warn_cond |=> !warning_flag_q)
    else $error("Acknowledge failed to clear warning flag");

  AST_IRQ: assert property (
    warning_flag_q && ctrl_q.warning_interrupt_enable |-> irq_out)
    else $error("Interrupt missing with enabled warning");

  AST_DET_RESET: assert property (
    rst_n_in && ctrl_q.detect_enable && ctrl_q.detect_reset_enable && below_detect_in
    && !stop_in |=> detect_reset_out)
    else $error("Detect reset not forced");

  AST_NO_RESET: assert property (
    !ctrl_q.detect_enable || !ctrl_q.detect_reset_enable |=> !detect_reset_out)
    else $error("Reset forced while disabled");

  AST_STOP_GATE: assert property (
    stop_in && !ctrl_q.detect_stop_enable |-> !detect_active_out)
    else $error("Detection alive in stop without enable");

  AST_LOCK_ONE: assert property (
    lock_one_q && wr_one |=> $stable(ctrl_q.detect_enable)
    && $stable(ctrl_q.detect_reset_enable))
    else $error("Locked bits of register one changed");

  AST_LOCK_STOP: assert property (
    lock_two_q && wr_two |=> $stable(stop_mode_select_q))
    else $error("Locked stop mode select changed");

  AST_LOCK_VOLT: assert property (
    lock_volt_q && wr_two |=> $stable(detect_voltage_select_q))
    else $error("Locked detect voltage select changed");

  AST_RETAIN: assert property (@(posedge clk_in) disable iff (1'b0)
    !rst_n_in && !por_in |=> $stable(detect_voltage_select_q)
    && $stable(warning_voltage_select_q))
    else $error("Voltage select lost on non power-on reset");

  AST_PPD_CLR: assert property (
    wr_two && wdata_in[B2_ACK] && !ppd_recovered_in |=> !ppd_flag_q)
    else $error("Recovery flag not cleared");

  AST_PPD_SET: assert property (ppd_recovered_in |=> ppd_flag_q ##1 ppd_flag_q
    || $past(wr_two))
    else $error("Recovery flag not set");

  AST_RD_ZERO: assert property (
    rd_in && addr_in == OFS_TWO |=> rdata_out[7:6] == 2'h0
    && rdata_out[2:1] == 2'h0)
    else $error("Unimplemented bits read nonzero");

  AST_RD_ZERO_ONE: assert property (
    rd_in && addr_in == OFS_ONE |=> rdata_out[B1_ACK] == 1'b0 && rdata_out[1] == 1'b0)
    else $error("Acknowledge or unused bit of register one read nonzero");

  AST_PPD_HOLD: assert property (
    ppd_flag_q && !(wr_two && wdata_in[B2_ACK]) |=> ppd_flag_q)
    else $error("Recovery flag dropped without acknowledge");

  // Stop enable stays writable after the lock, both ways
  AST_DSE_SET: assert property (
    wr_one && wdata_in[B1_DSE] |=> ctrl_q.detect_stop_enable)
    else $error("Detect stop enable not set by write");

  AST_DSE_CLR: assert property (
    wr_one && !wdata_in[B1_DSE] |=> !ctrl_q.detect_stop_enable)
    else $error("Detect stop enable not cleared by write");

  AST_FIRST_DE: assert property (
    !lock_one_q && wr_one && !wdata_in[B1_DE] |=> !ctrl_q.detect_enable)
    else $error("First write did not land on detect enable");

  AST_SMS_FIRST: assert property (
    !lock_two_q && wr_two && wdata_in[B2_SMS] |=> stop_mode_select_out)
    else $error("First write did not select partial power down stop");

  AST_BUF_ON: assert property (
    wr_one && wdata_in[B1_BUFE] |=> bandgap_buffer_enable_out)
    else $error("Bandgap buffer not enabled by write");

  AST_DVS_FIRST: assert property (
    !lock_volt_q && wr_two && wdata_in[B2_DVS] |=> detect_trip_code_out)
    else $error("First write did not select high detect point");

  AST_WVS_FREE: assert property (
    wr_two && wdata_in[B2_WVS] |=> warning_trip_code_out[0])
    else $error("Warning voltage select not set by write");

  AST_DETECT_OFF: assert property (
    !ctrl_q.detect_enable |-> !detect_active_out)
    else $error("Detection active with detect enable cleared");

  COV_WARN_ACK: cover property (warning_flag_q ##1 wr_one && wdata_in[B1_ACK]
    ##1 !warning_flag_q);
  COV_DET_RESET: cover property (detect_reset_out);
  COV_PPD: cover property (ppd_flag_q ##[1:20] !ppd_flag_q);
  COV_LOCKED_WR: cover property (lock_one_q && wr_one);
  COV_STOP_LIVE: cover property (stop_in && detect_active_out);

endmodule : low_voltage_and_stop_control

// *** test/low_voltage_and_stop_control_tb.sv ***
/*
  Self-checking bench for the low-voltage and stop control block.
  Assumes the block and its package are compiled first; the bench drives
  every input itself, at or 1 ns after a rising edge of a 100 MHz clock.
*/
`timescale 1ns/100ps

module low_voltage_and_stop_control_tb;
  import supply_ctrl_pkg::*;

  // ==========================================================================
  // Signals
  logic       clk_in;
  logic       rst_n_in;
  logic       por_in;
  logic [2:0] addr_in;
  logic [7:0] wdata_in;
  logic       wr_in;
  logic       rd_in;
  logic [7:0] rdata_out;
  logic       below_warning_in;
  logic       below_detect_in;
  logic       stop_in;
  logic       ppd_recovered_in;
  logic       detect_active_out;
  logic       detect_reset_out;
  logic       bandgap_buffer_enable_out;
  logic       stop_mode_select_out;
  logic       detect_trip_code_out;
  logic [1:0] warning_trip_code_out;
  logic       irq_out;
  int         failures;
  int         samples_checked;

  low_voltage_and_stop_control dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .por_in(por_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .below_warning_in(below_warning_in), .below_detect_in(below_detect_in),
    .stop_in(stop_in), .ppd_recovered_in(ppd_recovered_in),
    .detect_active_out(detect_active_out), .detect_reset_out(detect_reset_out),
    .bandgap_buffer_enable_out(bandgap_buffer_enable_out),
    .stop_mode_select_out(stop_mode_select_out),
    .detect_trip_code_out(detect_trip_code_out),
    .warning_trip_code_out(warning_trip_code_out), .irq_out(irq_out));

  // ==========================================================================
  // Clock, 10 ns period
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // ==========================================================================
  // Compare and bus tasks
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask : chk1

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in    <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in   <= 1'b0;
    #1;
    chk8(rdata_out, exp);
  endtask : rd

  task automatic reset_block(input logic por);
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    por_in   <= por;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    por_in   <= 1'b0;
  endtask : reset_block

  // Wait n rising clock edges, then 1 ns more so the outputs can be sampled
  task automatic settle(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : settle

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  // ==========================================================================
  // Scenarios
  task automatic s_reset_values;
    rd(OFS_ONE, 8'h14);
    rd(OFS_TWO, 8'h00);
    rd(OFS_EVT_ST, 8'h00);
    rd(3'h5, 8'h00);
    chk1(detect_active_out, 1'b1);
    chk1(irq_out, 1'b0);
    $display("done reset values");
  endtask : s_reset_values

  // Second writes to the locked bits must not land
  task automatic s_write_once;
    wr(OFS_ONE, 8'h01);
    rd(OFS_ONE, 8'h01);
    chk1(bandgap_buffer_enable_out, 1'b1);
    chk1(detect_active_out, 1'b0);
    below_detect_in <= 1'b1;
    settle(4);
    chk1(detect_reset_out, 1'b0);
    below_detect_in <= 1'b0;
    wr(OFS_ONE, 8'h14);
    rd(OFS_ONE, 8'h00);
    wr(OFS_TWO, 8'h31);
    rd(OFS_TWO, 8'h31);
    chk1(stop_mode_select_out, 1'b1);
    chk1(detect_trip_code_out, 1'b1);
    chk8({6'h00, warning_trip_code_out}, 8'h03);
    wr(OFS_TWO, 8'hce);
    rd(OFS_TWO, 8'h21);
    chk8({6'h00, warning_trip_code_out}, 8'h02);
    $display("done write once");
  endtask : s_write_once

  // Non power-on reset keeps the voltage selects and their lock
  task automatic s_soft_reset;
    below_warning_in <= 1'b1;
    reset_block(1'b0);
    settle(2);
    rd(OFS_ONE, 8'h94);
    rd(OFS_TWO, 8'h20);
    chk1(stop_mode_select_out, 1'b0);
    wr(OFS_TWO, 8'h01);
    rd(OFS_TWO, 8'h21);
    below_warning_in <= 1'b0;
    wr(OFS_ONE, 8'h54);
    rd(OFS_ONE, 8'h14);
    wr(OFS_EVT_CLR, 8'h07);
    $display("done soft reset");
  endtask : s_soft_reset

  task automatic s_warning;
    reset_block(1'b1);
    wr(OFS_ONE, 8'h34);
    below_warning_in <= 1'b1;
    @(posedge clk_in);
    below_warning_in <= 1'b0;
    rd(OFS_ONE, 8'hb4);
    chk1(irq_out, 1'b1);
    below_warning_in <= 1'b1;
    wr(OFS_ONE, 8'h60);
    rd(OFS_ONE, 8'hb4);
    below_warning_in <= 1'b0;
    wr(OFS_ONE, 8'h60);
    rd(OFS_ONE, 8'h34);
    chk1(irq_out, 1'b0);
    rd(OFS_EVT_ST, 8'h01);
    wr(OFS_EVT_EN, 8'h01);
    settle(1);
    chk1(irq_out, 1'b1);
    wr(OFS_EVT_CLR, 8'h01);
    rd(OFS_EVT_ST, 8'h00);
    chk1(irq_out, 1'b0);
    wr(3'h5, 8'hff);
    rd(3'h5, 8'h00);
    rd(OFS_EVT_EN, 8'h01);
    $display("done warning");
  endtask : s_warning

  // Detection in stop follows the stop enable; a detect forces reset
  task automatic s_stop_detect;
    int n;
    stop_in <= 1'b1;
    settle(1);
    chk1(detect_active_out, 1'b0);
    wr(OFS_ONE, 8'h08);
    rd(OFS_ONE, 8'h1c);
    chk1(detect_active_out, 1'b1);
    stop_in         <= 1'b0;
    below_detect_in <= 1'b1;
    n = 0;
    do begin
      settle(1);
      n++;
    end while (detect_reset_out !== 1'b1 && n < 4);
    chk1(detect_reset_out, 1'b1);
    if (detect_reset_out !== 1'b1) complete_run();
    rd(OFS_EVT_ST, 8'h02);
    below_detect_in <= 1'b0;
    reset_block(1'b0);
    $display("done stop and detect");
  endtask : s_stop_detect

  task automatic s_ppd;
    ppd_recovered_in <= 1'b1;
    @(posedge clk_in);
    ppd_recovered_in <= 1'b0;
    rd(OFS_TWO, 8'h08);
    rd(OFS_EVT_ST, 8'h04);
    wr(OFS_TWO, 8'h0c);
    rd(OFS_TWO, 8'h00);
    $display("done partial power down");
  endtask : s_ppd

  // ==========================================================================
  // Main sequence
  initial begin
    failures         = 0;
    samples_checked  = 0;
    rst_n_in         = 1'b0;
    por_in           = 1'b1;
    addr_in          = 3'h0;
    wdata_in         = 8'h00;
    wr_in            = 1'b0;
    rd_in            = 1'b0;
    below_warning_in = 1'b0;
    below_detect_in  = 1'b0;
    stop_in          = 1'b0;
    ppd_recovered_in = 1'b0;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    por_in   <= 1'b0;
    s_reset_values();
    s_write_once();
    s_soft_reset();
    s_warning();
    s_stop_detect();
    s_ppd();
    complete_run();
  end

endmodule : low_voltage_and_stop_control_tb
